/* File: verilog/sos_status_output_selector.sv */
// Status output selector driving the open-collector terminal and the relay
`timescale 1ns/100ps
`default_nettype none
`include "sos_consts.svh"

// Behaviour
// RL1 - Match mode: on while |commanded minus output| is at most half bandwidth.
// RL2 - Bandwidth spans 0 to 400 Hz, default 10.0; above max frequency rejected.
// RL3 - Level match mode: commanded equals level and match mode condition holds.
// RL4 - Level spans 0 to 400 Hz, default 30.0; above max frequency rejected.
// RL5 - Window mode: on while |level minus running| is at most half bandwidth.
// RL6 - Threshold: accel on at level; decel stays on above level minus half band.
// RL7 - Inverted threshold: same hysteresis as threshold mode, inverted polarity.
// RL8 - Item eight follows the overvoltage trip.
// RL9 - Item nine follows the undervoltage trip.
// RL10 - Item ten follows the heatsink overtemperature trip.
// RL11 - Item eleven follows loss of the frequency command.
// RL12 - Item twelve: run command present and power stage producing voltage.
// RL13 - Item thirteen while stopped; item fourteen while at constant speed.
// RL14 - Item sixteen while healthy and waiting for a run command.
// RL15 - Item seventeen drives the output from the fault mask.
// RL16 - Fault item with mask 2 reacts to any trip except undervoltage.
// RL17 - Terminal and relay each have their own item selection.
// RL18 - Mask bit 0 undervoltage, bit 1 other trips, bit 2 restart attempts.
// RL19 - Items five, six, seven, fifteen pass overload, stall, search flags.
module sos_status_output_selector
    import sos_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Frequencies from the control core, 0.1 Hz steps
    input wire logic [15:0] cmd_freq,
    input wire logic [15:0] run_freq,
    input wire logic accelerating,
    input wire logic decelerating,
    // Status flags from the control core
    input wire logic motor_overload_flag,
    input wire logic drive_overload_flag,
    input wire logic stall_flag,
    input wire logic speed_search_flag,
    input wire logic overvolt_trip,
    input wire logic undervolt_trip,
    input wire logic heatsink_overtemp_trip,
    input wire logic any_trip,
    input wire logic restart_attempt,
    input wire logic cmd_loss,
    input wire logic run_cmd,
    input wire logic output_active,
    input wire logic stopped,
    input wire logic constant_run,
    input wire logic waiting_run,
    // Outputs to the external sequence, plus the interrupt
    output logic open_collector_output,
    output logic programmable_relay,
    output logic irq
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Absolute difference of two frequencies
    function automatic sos_freq_t abs_diff(input sos_freq_t a, input sos_freq_t b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction

    // Picks the condition an item selection points at
    function automatic logic pick_item(input sos_item_t sel, input logic [17:0] cond);
        pick_item = (sel <= `SOS_ITEM_LAST) ? cond[sel] : 1'b0;
    endfunction

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    sos_item_t terminal_item_select_q;
    sos_item_t relay_item_select_q;
    sos_flags_t fault_indication_mask_q;
    sos_freq_t freq_detect_level_q;
    sos_freq_t freq_detect_bandwidth_q;
    sos_freq_t max_frequency_limit_q;
    sos_flags_t irq_status_q;
    sos_flags_t irq_mask_q;
    logic thresh_q;
    logic oc_q;
    logic relay_q;
    logic irq_q;
    logic [31:0] rdata_q;

    logic wr_term;
    logic wr_relay;
    logic wr_mask;
    logic wr_level;
    logic wr_band;
    logic wr_maxf;
    logic wr_status;
    logic wr_irqmask;
    logic reject_evt;
    sos_freq_t wfreq;

    // Write decode
    assign wfreq = reg_wdata[15:0];
    assign wr_term = reg_wr && (reg_addr == `SOS_ADDR_TERM_SEL);
    assign wr_relay = reg_wr && (reg_addr == `SOS_ADDR_RELAY_SEL);
    assign wr_mask = reg_wr && (reg_addr == `SOS_ADDR_FAULT_MASK);
    assign wr_level = reg_wr && (reg_addr == `SOS_ADDR_LEVEL);
    assign wr_band = reg_wr && (reg_addr == `SOS_ADDR_BANDWIDTH);
    assign wr_maxf = reg_wr && (reg_addr == `SOS_ADDR_MAX_FREQ);
    assign wr_status = reg_wr && (reg_addr == `SOS_ADDR_IRQ_STATUS);
    assign wr_irqmask = reg_wr && (reg_addr == `SOS_ADDR_IRQ_MASK);

    // Out-of-range writes leave the old value and raise a sticky flag
    assign reject_evt = (wr_term && (reg_wdata[31:0] > 32'h0000_0011))
        || (wr_relay && (reg_wdata[31:0] > 32'h0000_0011))
        || (wr_level && ((reg_wdata[31:16] != 16'h0000) || (wfreq > max_frequency_limit_q)))
        || (wr_band && ((reg_wdata[31:16] != 16'h0000) || (wfreq > max_frequency_limit_q)))
        || (wr_maxf && ((reg_wdata[31:16] != 16'h0000) || (wfreq > `SOS_FREQ_CEIL)));

    // Independent selections for terminal and relay
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            terminal_item_select_q <= `SOS_TERM_SEL_RST;
            relay_item_select_q <= `SOS_RELAY_SEL_RST;
        end
        else
        begin
            if (wr_term && (reg_wdata[31:0] <= 32'h0000_0011))
            begin
                terminal_item_select_q <= reg_wdata[4:0]; // RL17
            end
            if (wr_relay && (reg_wdata[31:0] <= 32'h0000_0011))
            begin
                relay_item_select_q <= reg_wdata[4:0]; // RL17
            end
        end
    end

    // Fault mask, three bits, upper bits ignored
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fault_indication_mask_q <= `SOS_FAULT_MASK_RST;
        end
        else if (wr_mask)
        begin
            fault_indication_mask_q <= reg_wdata[2:0]; // RL18
        end
    end

    // Level and bandwidth, written only when not above the configured maximum frequency
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            freq_detect_level_q <= `SOS_LEVEL_RST;
            freq_detect_bandwidth_q <= `SOS_BANDWIDTH_RST;
        end
        else
        begin
            if (wr_level && (reg_wdata[31:16] == 16'h0000) && (wfreq <= max_frequency_limit_q))
            begin
                freq_detect_level_q <= wfreq; // RL4
            end
            if (wr_band && (reg_wdata[31:16] == 16'h0000) && (wfreq <= max_frequency_limit_q))
            begin
                freq_detect_bandwidth_q <= wfreq; // RL2
            end
        end
    end

    // Maximum frequency; lowering it does not clip settings already stored
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            max_frequency_limit_q <= `SOS_MAX_FREQ_RST;
        end
        else if (wr_maxf && (reg_wdata[31:16] == 16'h0000) && (wfreq <= `SOS_FREQ_CEIL))
        begin
            max_frequency_limit_q <= wfreq;
        end
    end

    // ------------------------------------------------------------------------
    // Frequency detection
    // ------------------------------------------------------------------------
    sos_freq_t half_band;
    sos_freq_t low_edge;
    logic match_ok;
    logic level_match_ok;
    logic window_ok;
    logic thresh_d;
    sos_ramp_e ramp;

    // Half bandwidth truncates, so an odd 0.1 Hz step narrows the window
    assign half_band = {1'b0, freq_detect_bandwidth_q[15:1]};
    // Saturate at zero so a small level does not wrap the lower edge
    assign low_edge = (freq_detect_level_q > half_band) ? (freq_detect_level_q - half_band) : 16'h0000;
    assign match_ok = abs_diff(cmd_freq, run_freq) <= half_band; // RL1
    assign level_match_ok = (cmd_freq == freq_detect_level_q) && match_ok; // RL3
    assign window_ok = abs_diff(freq_detect_level_q, run_freq) <= half_band; // RL5

    // Ramp direction; accel wins if the core claims both
    always_comb
    begin
        if (accelerating)
        begin
            ramp = SOS_RAMP_ACCEL;
        end
        else if (decelerating)
        begin
            ramp = SOS_RAMP_DECEL;
        end
        else
        begin
            ramp = SOS_RAMP_HOLD;
        end
    end

    // Hysteresis state shared by both threshold items
    always_comb
    begin
        case (ramp)
            SOS_RAMP_ACCEL: thresh_d = run_freq >= freq_detect_level_q; // RL6
            SOS_RAMP_DECEL: thresh_d = thresh_q && (run_freq > low_edge); // RL6
            SOS_RAMP_HOLD: thresh_d = thresh_q;
            default: thresh_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            thresh_q <= 1'b0;
        end
        else
        begin
            thresh_q <= thresh_d;
        end
    end

    // ------------------------------------------------------------------------
    // Item conditions and output selection
    // ------------------------------------------------------------------------
    logic [17:0] cond;
    logic fault_ok;
    logic oc_d;
    logic relay_d;

    // Fault indication from the mask bits
    assign fault_ok = (fault_indication_mask_q[`SOS_MASK_UNDERVOLT] && undervolt_trip)
        || (fault_indication_mask_q[`SOS_MASK_OTHER_TRIP] && any_trip && !undervolt_trip)
        || (fault_indication_mask_q[`SOS_MASK_RESTART] && restart_attempt); // RL15 RL16 RL18

    // Condition vector indexed by item code
    always_comb
    begin
        cond = 18'h00000;
        cond[`SOS_ITEM_MATCH] = match_ok; // RL1
        cond[`SOS_ITEM_LEVEL_MATCH] = level_match_ok; // RL3
        cond[`SOS_ITEM_WINDOW] = window_ok; // RL5
        cond[`SOS_ITEM_THRESH] = thresh_q; // RL6
        cond[`SOS_ITEM_THRESH_INV] = !thresh_q; // RL7
        cond[`SOS_ITEM_MOTOR_OL] = motor_overload_flag; // RL19
        cond[`SOS_ITEM_DRIVE_OL] = drive_overload_flag; // RL19
        cond[`SOS_ITEM_STALL] = stall_flag; // RL19
        cond[`SOS_ITEM_OVERVOLT] = overvolt_trip; // RL8
        cond[`SOS_ITEM_UNDERVOLT] = undervolt_trip; // RL9
        cond[`SOS_ITEM_HEATSINK] = heatsink_overtemp_trip; // RL10
        cond[`SOS_ITEM_CMD_LOSS] = cmd_loss; // RL11
        cond[`SOS_ITEM_RUNNING] = run_cmd && output_active; // RL12
        cond[`SOS_ITEM_STOPPED] = stopped; // RL13
        cond[`SOS_ITEM_CONSTANT] = constant_run; // RL13
        cond[`SOS_ITEM_SEARCH] = speed_search_flag; // RL19
        cond[`SOS_ITEM_WAITING] = waiting_run; // RL14
        cond[`SOS_ITEM_FAULT] = fault_ok; // RL15
    end

    assign oc_d = pick_item(terminal_item_select_q, cond); // RL17
    assign relay_d = pick_item(relay_item_select_q, cond); // RL17

    // Outputs registered so the pins never glitch on decode
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oc_q <= 1'b0;
            relay_q <= 1'b0;
        end
        else
        begin
            oc_q <= oc_d;
            relay_q <= relay_d;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    sos_flags_t irq_set;

    assign irq_set = {reject_evt, relay_d && !relay_q, oc_d && !oc_q};

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_status_q <= 3'h0;
        end
        else if (wr_status)
        begin
            irq_status_q <= (irq_status_q & ~reg_wdata[2:0]) | irq_set;
        end
        else
        begin
            irq_status_q <= irq_status_q | irq_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_mask_q <= 3'h0;
        end
        else if (wr_irqmask)
        begin
            irq_mask_q <= reg_wdata[2:0];
        end
    end

    // Level interrupt follows masked status one cycle later
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    logic [31:0] rdata_d;

    // Unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            `SOS_ADDR_TERM_SEL: rdata_d = {27'h0, terminal_item_select_q};
            `SOS_ADDR_RELAY_SEL: rdata_d = {27'h0, relay_item_select_q};
            `SOS_ADDR_FAULT_MASK: rdata_d = {29'h0, fault_indication_mask_q};
            `SOS_ADDR_LEVEL: rdata_d = {16'h0, freq_detect_level_q};
            `SOS_ADDR_BANDWIDTH: rdata_d = {16'h0, freq_detect_bandwidth_q};
            `SOS_ADDR_MAX_FREQ: rdata_d = {16'h0, max_frequency_limit_q};
            `SOS_ADDR_OUT_STATE: rdata_d = {29'h0, thresh_q, relay_q, oc_q};
            `SOS_ADDR_IRQ_STATUS: rdata_d = {29'h0, irq_status_q};
            `SOS_ADDR_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign open_collector_output = oc_q;
    assign programmable_relay = relay_q;
    assign irq = irq_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    match_mode_a: assert property ((terminal_item_select_q == `SOS_ITEM_MATCH) && !wr_term
        |=> open_collector_output == (abs_diff($past(cmd_freq), $past(run_freq)) <= $past(half_band))) // RL1
        else $error("match mode terminal wrong");
    band_limit_a: assert property (wr_band && (wfreq > max_frequency_limit_q)
        |=> $stable(freq_detect_bandwidth_q)) // RL2
        else $error("bandwidth above max accepted");
    level_limit_a: assert property (freq_detect_level_q <= `SOS_FREQ_CEIL) // RL4
        else $error("level above ceiling");
    level_match_a: assert property ((terminal_item_select_q == `SOS_ITEM_LEVEL_MATCH) && !wr_term
        && (cmd_freq != freq_detect_level_q) |=> !open_collector_output) // RL3
        else $error("level match terminal on without equality");
    window_mode_a: assert property ((terminal_item_select_q == `SOS_ITEM_WINDOW) && !wr_term
        && (abs_diff(freq_detect_level_q, run_freq) > half_band) |=> !open_collector_output) // RL5
        else $error("window mode terminal on outside window");
    thresh_accel_a: assert property (accelerating && (run_freq >= freq_detect_level_q) |=> thresh_q) // RL6
        else $error("threshold not set on accel");
    thresh_decel_a: assert property (!accelerating && decelerating && (run_freq <= low_edge) |=> !thresh_q) // RL6
        else $error("threshold held below lower edge");
    thresh_inv_a: assert property ((relay_item_select_q == `SOS_ITEM_THRESH_INV) && !wr_relay
        |=> programmable_relay == !$past(thresh_q)) // RL7
        else $error("inverted threshold polarity wrong");
    fault_mask_a: assert property ((relay_item_select_q == `SOS_ITEM_FAULT) && !wr_relay
        && (fault_indication_mask_q == 3'h2) && undervolt_trip && !restart_attempt
        |=> !programmable_relay) // RL16
        else $error("fault relay on undervoltage with mask 2");
    running_a: assert property ((terminal_item_select_q == `SOS_ITEM_RUNNING) && !wr_term
        |=> open_collector_output == ($past(run_cmd) && $past(output_active))) // RL12
        else $error("running item wrong");
    irq_level_a: assert property (|(irq_status_q & irq_mask_q) |=> irq)
        else $error("interrupt not raised");

    relay_fault_c: cover property ((relay_item_select_q == `SOS_ITEM_FAULT) ##1 programmable_relay);
    thresh_cycle_c: cover property (thresh_q ##[1:20] !thresh_q);
    reject_c: cover property (reject_evt ##1 irq_status_q[`SOS_IRQ_REJECT]);
    both_on_c: cover property (open_collector_output && programmable_relay);

endmodule
`default_nettype wire

/* File: verilog/sos_consts.svh */
// Offsets, field positions, reset values and encodings of the status output selector
`ifndef SOS_CONSTS_SVH
`define SOS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SOS_ADDR_TERM_SEL 8'h00
`define SOS_ADDR_RELAY_SEL 8'h04
`define SOS_ADDR_FAULT_MASK 8'h08
`define SOS_ADDR_LEVEL 8'h0C
`define SOS_ADDR_BANDWIDTH 8'h10
`define SOS_ADDR_MAX_FREQ 8'h14
`define SOS_ADDR_OUT_STATE 8'h18
`define SOS_ADDR_IRQ_STATUS 8'h1C
`define SOS_ADDR_IRQ_MASK 8'h20

// ----------------------------------------------------------------------------
// Reset values and limits (frequencies in 0.1 Hz steps)
// ----------------------------------------------------------------------------
`define SOS_TERM_SEL_RST 5'h0C
`define SOS_RELAY_SEL_RST 5'h11
`define SOS_FAULT_MASK_RST 3'h2
`define SOS_LEVEL_RST 16'h012C
`define SOS_BANDWIDTH_RST 16'h0064
`define SOS_MAX_FREQ_RST 16'h0FA0
`define SOS_FREQ_CEIL 16'h0FA0
`define SOS_ITEM_LAST 5'h11

// ----------------------------------------------------------------------------
// Item encodings
// ----------------------------------------------------------------------------
`define SOS_ITEM_MATCH 5'h00
`define SOS_ITEM_LEVEL_MATCH 5'h01
`define SOS_ITEM_WINDOW 5'h02
`define SOS_ITEM_THRESH 5'h03
`define SOS_ITEM_THRESH_INV 5'h04
`define SOS_ITEM_MOTOR_OL 5'h05
`define SOS_ITEM_DRIVE_OL 5'h06
`define SOS_ITEM_STALL 5'h07
`define SOS_ITEM_OVERVOLT 5'h08
`define SOS_ITEM_UNDERVOLT 5'h09
`define SOS_ITEM_HEATSINK 5'h0A
`define SOS_ITEM_CMD_LOSS 5'h0B
`define SOS_ITEM_RUNNING 5'h0C
`define SOS_ITEM_STOPPED 5'h0D
`define SOS_ITEM_CONSTANT 5'h0E
`define SOS_ITEM_SEARCH 5'h0F
`define SOS_ITEM_WAITING 5'h10
`define SOS_ITEM_FAULT 5'h11

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SOS_MASK_UNDERVOLT 0
`define SOS_MASK_OTHER_TRIP 1
`define SOS_MASK_RESTART 2
`define SOS_IRQ_TERM_RISE 0
`define SOS_IRQ_RELAY_RISE 1
`define SOS_IRQ_REJECT 2

`endif

/* File: verilog/sos_pkg.sv */
// Types shared by the status output selector
package sos_pkg;
    typedef logic [15:0] sos_freq_t;
    typedef logic [4:0] sos_item_t;
    typedef logic [2:0] sos_flags_t;
    typedef enum logic [1:0] {SOS_RAMP_HOLD, SOS_RAMP_ACCEL, SOS_RAMP_DECEL} sos_ramp_e;
endpackage

/* File: dv/sos_seq_model.sv */
// Model of the external sequence controller that reads the terminal and relay
`timescale 1ns/100ps
`default_nettype none

module sos_seq_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Status lines from the drive
    input wire logic term_in,
    input wire logic relay_in,
    // Latched view of both lines
    output logic [1:0] seen_q
);
    // The far side only samples; it never drives back into the selector
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            seen_q <= 2'h0;
        else
            seen_q <= {relay_in, term_in};
    end
endmodule

`default_nettype wire

/* File: dv/test_status_output_selector.sv */
// Self-checking bench for the status output selector
`timescale 1ns/100ps
`default_nettype none

module test_status_output_selector;
    import sos_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    sos_freq_t cmd = 16'h0000;
    sos_freq_t run = 16'h0000;
    logic acc = 1'b0;
    logic dec = 1'b0;
    logic [14:0] fl = 15'h0000;
    logic term, relay, irq, pend = 1'b0;
    logic [1:0] seen;
    logic [34:0] notes[$];
    logic [34:0] note;
    logic xt = 1'b0, xr = 1'b0, xi = 1'b0;
    int error_cnt = 0, checked = 0, lvl = 300, bw = 100, it;
    logic [2:0] mask = 3'h2;
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [15:0] rv[7] = '{16'h000C, 16'h0011, 16'h0002, 16'h012C, 16'h0064, 16'h0FA0, 16'h0000};
    logic [3:0] ha = 4'h9, hd = 4'hE, hs = 4'h3;
    logic [15:0] hr[4] = '{16'h012C, 16'h0104, 16'h00FA, 16'h012B};

    always #20 clk = ~clk;

    sos_status_output_selector i_sos_status_output_selector (
        .clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .cmd_freq(cmd), .run_freq(run), .accelerating(acc), .decelerating(dec),
        .motor_overload_flag(fl[0]), .drive_overload_flag(fl[1]), .stall_flag(fl[2]),
        .speed_search_flag(fl[3]), .overvolt_trip(fl[4]), .undervolt_trip(fl[5]),
        .heatsink_overtemp_trip(fl[6]), .any_trip(fl[7]), .restart_attempt(fl[8]), .cmd_loss(fl[9]),
        .run_cmd(fl[10]), .output_active(fl[11]), .stopped(fl[12]), .constant_run(fl[13]),
        .waiting_run(fl[14]), .open_collector_output(term), .programmable_relay(relay), .irq(irq));

    sos_seq_model i_sos_seq_model (.clk(clk), .rst_b(rst_b), .term_in(term), .relay_in(relay), .seen_q(seen));

    // ------------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Expected answer is noted when the strobe is issued
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back({xi, xr, xt, d});
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic test_done;
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (pend)
        begin
            note = notes.pop_front();
            cmp("rdata", note[31:0], rdata);
            cmp("pins", {29'h0, note[34:32]}, {29'h0, irq, relay, term});
            cmp("seen", {30'h0, note[33:32]}, {30'h0, seen});
        end
        pend <= rd;
    end

    // Reference value of one item from the present inputs
    function automatic logic item_val(input int n);
        int m = (cmd > run) ? cmd - run : run - cmd;
        int w = (lvl > run) ? lvl - run : run - lvl;
        case (n)
            0: return m <= bw / 2;
            1: return cmd == lvl && m <= bw / 2;
            2: return w <= bw / 2;
            5: return fl[0];
            6: return fl[1];
            7: return fl[2];
            8: return fl[4];
            9: return fl[5];
            10: return fl[6];
            11: return fl[9];
            12: return fl[10] & fl[11];
            13: return fl[12];
            14: return fl[13];
            15: return fl[3];
            16: return fl[14];
            17: return (mask[0] & fl[5]) | (mask[1] & fl[7] & ~fl[5]) | (mask[2] & fl[8]);
            default: return 1'b0;
        endcase
    endfunction

    initial
    begin
        #(40 * 20000);
        error_cnt++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(70));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ra[k])
            rd_reg(ra[k], {16'h0, rv[k]});
        rd_reg(8'h24, 32'h0);
        // Every item but 3, 4 and 17 in turn on the terminal while the relay shows faults
        for (int i = 0; i < 60; i++)
        begin
            it = (i % 17 == 3 || i % 17 == 4) ? 16 - i % 17 : i % 17;
            lvl = 200 + $urandom % 200;
            bw = $urandom % 120;
            mask = 3'($urandom % 8);
            wr_reg(8'h00, it);
            wr_reg(8'h04, 32'h11);
            wr_reg(8'h08, {29'h0, mask});
            wr_reg(8'h0C, lvl);
            wr_reg(8'h10, bw);
            run <= 16'(lvl - 60 + $urandom % 120);
            cmd <= ($urandom % 2) ? 16'(lvl) : 16'(lvl - 60 + $urandom % 120);
            fl <= 15'($urandom);
            repeat (3) @(posedge clk);
            xt = item_val(it);
            xr = item_val(17);
            rd_reg(8'h24, 32'h0);
        end
        // Threshold hysteresis, plain on the terminal and inverted on the relay
        lvl = 300;
        bw = 100;
        wr_reg(8'h0C, lvl);
        wr_reg(8'h10, bw);
        wr_reg(8'h00, 32'h3);
        wr_reg(8'h04, 32'h4);
        fl <= 15'h0000;
        for (int k = 0; k < 5; k++)
        begin
            acc <= (k == 4) ? 1'b1 : ha[k];
            dec <= (k == 4) ? 1'b1 : hd[k];
            run <= (k == 4) ? 16'h012C : hr[k];
            repeat (4) @(posedge clk);
            xt = (k == 4) ? 1'b1 : hs[k];
            xr = ~xt;
            rd_reg(8'h18, {29'h0, xt, xr, xt});
        end
        // Refused writes raise the reject event
        wr_reg(8'h1C, 32'h7);
        wr_reg(8'h00, 32'h12);
        wr_reg(8'h20, 32'h4);
        repeat (2) @(posedge clk);
        xi = 1'b1;
        rd_reg(8'h00, 32'h3);
        rd_reg(8'h1C, 32'h4);
        wr_reg(8'h1C, 32'h4);
        repeat (2) @(posedge clk);
        xi = 1'b0;
        rd_reg(8'h1C, 32'h0);
        wr_reg(8'h14, 32'hC8);
        wr_reg(8'h10, 32'hC9);
        wr_reg(8'h0C, 32'h10000);
        wr_reg(8'h10, 32'hC8);
        wr_reg(8'h14, 32'hFA1);
        repeat (2) @(posedge clk);
        xi = 1'b1;
        rd_reg(8'h10, 32'hC8);
        rd_reg(8'h0C, 32'h12C);
        rd_reg(8'h14, 32'hC8);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule

`default_nettype wire
